//--- rtl/alarm_and_remote_cal_control.sv
// alarm relays, remote span handshake and one-shot status contacts
`include "alarm_cal_cfg.svh"

module alarm_and_remote_cal_control #(
  parameter int unsigned DONE_HOLD_CYCLES = `DONE_HOLD_S * `REF_CLK_HZ
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 srst_i,
  // avalon-mm slave
  input  wire logic [4:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  output logic      [31:0]          avs_readdata_o,
  output logic                      avs_waitrequest_o,
  // analyzer side, same clock
  input  wire alarm_cal_pkg::conc_t conc_i,
  input  wire logic                 span_cal_done_i,
  input  wire logic                 meas_done_i,
  output logic                      span_cal_start_o,
  output logic                      meas_start_o,
  output alarm_cal_pkg::conc_t      held_reading_o,
  // pins
  input  wire logic                 remote_span_i,
  input  wire logic                 start_meas_i,
  input  wire logic                 supply_fault_i,
  output logic                      alarm1_coil_o,
  output logic                      alarm2_coil_o,
  output logic                      sys_alarm_coil_o,
  output logic                      cal_contact_o,
  output logic                      idle_contact_o,
  output logic                      meas_contact_o,
  output logic                      done_contact_o
);
  logic [31:0]               ctrl_q;
  alarm_cal_pkg::conc_t      thresh1_q;
  alarm_cal_pkg::conc_t      thresh2_q;
  logic                      resp_q;
  logic                      wr_take;
  logic                      rd_take;
  logic [31:0]               rd_d;
  logic [2:0]                pins_sync;
  logic                      span_s;
  logic                      start_s;
  logic                      fault_s;
  logic                      start_prev_q;
  logic                      start_rise;
  logic                      ack1;
  logic                      ack2;
  logic                      alm1_active;
  logic                      alm2_active;
  logic                      sys_alarm_q;
  alarm_cal_pkg::cal_state_t cal_state_q;
  alarm_cal_pkg::shot_state_t shot_state_q;
  logic [31:0]               done_cnt_q;
  logic                      continuous;
  logic                      alm1_en;
  logic                      alm1_high;
  logic                      alm1_failsafe;
  logic                      alm1_latch;
  logic                      alm2_en;
  logic                      alm2_high;
  logic                      alm2_failsafe;
  logic                      alm2_latch;
  logic                      cmd_hit;
  logic                      hold_end;
  alarm_cal_pkg::shot_state_t shot_state_d;

  // ctrl field pick for alarm n
  function automatic logic ctrl_bit(input logic [31:0] c, input int n, input int pos);
    ctrl_bit = c[n * `CTRL_ALM_STRIDE + pos];
  endfunction

  assign continuous = ctrl_q[`CTRL_CONT_BIT];

  // per-alarm settings unpacked from the control word
  assign alm1_en       = ctrl_bit(ctrl_q, 0, `CTRL_EN_BIT);
  assign alm1_high     = ctrl_bit(ctrl_q, 0, `CTRL_HIGH_BIT);
  assign alm1_failsafe = ctrl_bit(ctrl_q, 0, `CTRL_FAILSAFE_BIT);
  assign alm1_latch    = ctrl_bit(ctrl_q, 0, `CTRL_LATCH_BIT);
  assign alm2_en       = ctrl_bit(ctrl_q, 1, `CTRL_EN_BIT);
  assign alm2_high     = ctrl_bit(ctrl_q, 1, `CTRL_HIGH_BIT);
  assign alm2_failsafe = ctrl_bit(ctrl_q, 1, `CTRL_FAILSAFE_BIT);
  assign alm2_latch    = ctrl_bit(ctrl_q, 1, `CTRL_LATCH_BIT);

  // pin inputs cross into the clock domain
  pin_sync #(
    .W (3)
  ) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .async_i   ({supply_fault_i, start_meas_i, remote_span_i}),
    .sync_o    (pins_sync)
  );

  assign span_s  = pins_sync[0];
  assign start_s = pins_sync[1];
  assign fault_s = pins_sync[2];

  // ---------------- bus slave ----------------
  // one wait cycle on every access, then answer
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~resp_q;
  assign wr_take           = avs_write_i & resp_q;
  assign rd_take           = avs_read_i & ~resp_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      resp_q <= 1'b0;
    else
      resp_q <= (avs_read_i | avs_write_i) & ~resp_q;
  end

  // read mux, unmapped reads return zero
  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (avs_address_i)
      `REG_CTRL_OFS:    rd_d = ctrl_q;
      `REG_THRESH1_OFS: rd_d = {16'h0000, thresh1_q};
      `REG_THRESH2_OFS: rd_d = {16'h0000, thresh2_q};
      `REG_STATUS_OFS:
      begin
        rd_d[`STAT_ALM1_BIT]                 = alm1_active;
        rd_d[`STAT_ALM2_BIT]                 = alm2_active;
        rd_d[`STAT_SYS_BIT]                  = sys_alarm_q;
        rd_d[`STAT_CAL_BIT]                  = (cal_state_q == alarm_cal_pkg::CAL_SPAN);
        rd_d[`STAT_SHOT_LSB+1:`STAT_SHOT_LSB] = shot_state_q;
        rd_d[`STAT_SPAN_BIT]                 = span_s;
        rd_d[`STAT_START_BIT]                = start_s;
      end
      `REG_READING_OFS: rd_d = {16'h0000, held_reading_o};
      default:          rd_d = 32'h0000_0000;
    endcase
  end

  // read data registered in the wait cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (rd_take)
      avs_readdata_o <= rd_d;
  end

  // configuration registers
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      ctrl_q    <= `CTRL_RESET;
      thresh1_q <= `THRESH_RESET;
      thresh2_q <= `THRESH_RESET;
    end
    else if (wr_take)
    begin
      case (avs_address_i)
        `REG_CTRL_OFS:    ctrl_q    <= avs_writedata_i & 32'h0000_01FF;
        `REG_THRESH1_OFS: thresh1_q <= avs_writedata_i[15:0];
        `REG_THRESH2_OFS: thresh2_q <= avs_writedata_i[15:0];
        default:          ctrl_q    <= ctrl_q;
      endcase
    end
  end

  // acknowledge strobes for latched alarms
  assign cmd_hit = wr_take & (avs_address_i == `REG_CMD_OFS);
  assign ack1    = cmd_hit & avs_writedata_i[`CMD_ACK1_BIT];
  assign ack2    = cmd_hit & avs_writedata_i[`CMD_ACK2_BIT];

  // ---------------- alarms ----------------
  // threshold alarm 1
  threshold_alarm u_alarm1 (
    .ref_clk_i  (ref_clk_i),
    .srst_i     (srst_i),
    .conc_i     (conc_i),
    .thresh_i   (thresh1_q),
    .enable_i   (alm1_en),
    .high_i     (alm1_high),
    .failsafe_i (alm1_failsafe),
    .latch_i    (alm1_latch),
    .ack_i      (ack1),
    .active_o   (alm1_active),
    .coil_o     (alarm1_coil_o)
  );

  // threshold alarm 2
  threshold_alarm u_alarm2 (
    .ref_clk_i  (ref_clk_i),
    .srst_i     (srst_i),
    .conc_i     (conc_i),
    .thresh_i   (thresh2_q),
    .enable_i   (alm2_en),
    .high_i     (alm2_high),
    .failsafe_i (alm2_failsafe),
    .latch_i    (alm2_latch),
    .ack_i      (ack2),
    .active_o   (alm2_active),
    .coil_o     (alarm2_coil_o)
  );

  // system alarm: latches, only srst_i clears it
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      sys_alarm_q <= 1'b0;
    else if (fault_s)
      sys_alarm_q <= 1'b1;
  end

  // system relay is always failsafe
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      sys_alarm_coil_o <= 1'b0;
    else
      sys_alarm_coil_o <= ~sys_alarm_q;
  end

  // ---------------- remote span ----------------
  // analyze polls the span input; spanning ignores it
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      cal_state_q <= alarm_cal_pkg::CAL_ANALYZE;
    else
    begin
      case (cal_state_q)
        alarm_cal_pkg::CAL_ANALYZE:
          if (span_s && continuous)
            cal_state_q <= alarm_cal_pkg::CAL_SPAN;
        alarm_cal_pkg::CAL_SPAN:
          if (span_cal_done_i)
            cal_state_q <= alarm_cal_pkg::CAL_ANALYZE;
        default:
          cal_state_q <= alarm_cal_pkg::CAL_ANALYZE;
      endcase
    end
  end

  // start pulse to the sequencer and calibration contact
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      span_cal_start_o <= 1'b0;
      cal_contact_o    <= 1'b0;
    end
    else
    begin
      span_cal_start_o <= (cal_state_q == alarm_cal_pkg::CAL_ANALYZE) & span_s & continuous;
      cal_contact_o    <= (cal_state_q == alarm_cal_pkg::CAL_ANALYZE)
                          ? (span_s & continuous)
                          : ~span_cal_done_i;
    end
  end

  // ---------------- one-shot measurement ----------------
  // rising edge of start input
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      start_prev_q <= 1'b0;
    else
      start_prev_q <= start_s;
  end

  assign start_rise = start_s & ~start_prev_q & ~continuous;

  // next one-shot state, shared by the state and contact registers
  function automatic alarm_cal_pkg::shot_state_t shot_next(
    input alarm_cal_pkg::shot_state_t s,
    input logic                       rise,
    input logic                       done,
    input logic                       expired
  );
    shot_next = s;
    case (s)
      alarm_cal_pkg::SHOT_IDLE:
        if (rise)
          shot_next = alarm_cal_pkg::SHOT_MEAS;
      alarm_cal_pkg::SHOT_MEAS:
        if (done)
          shot_next = alarm_cal_pkg::SHOT_DONE;
      alarm_cal_pkg::SHOT_DONE:
        if (rise)
          shot_next = alarm_cal_pkg::SHOT_MEAS;
        else if (expired)
          shot_next = alarm_cal_pkg::SHOT_IDLE;
      default:
        shot_next = alarm_cal_pkg::SHOT_IDLE;
    endcase
  endfunction

  // done interval ends on its last counted cycle
  assign hold_end     = (done_cnt_q == DONE_HOLD_CYCLES - 1);
  assign shot_state_d = shot_next(shot_state_q, start_rise, meas_done_i, hold_end);

  // idle -> measure -> done -> idle
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      shot_state_q <= alarm_cal_pkg::SHOT_IDLE;
    else
      shot_state_q <= shot_state_d;
  end

  // done hold timer
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      done_cnt_q <= 32'h0000_0000;
    else if (shot_state_q == alarm_cal_pkg::SHOT_DONE)
      done_cnt_q <= done_cnt_q + 32'h0000_0001;
    else
      done_cnt_q <= 32'h0000_0000;
  end

  // measurement start pulse to the sequencer
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      meas_start_o <= 1'b0;
    else
      meas_start_o <= start_rise & (shot_state_q != alarm_cal_pkg::SHOT_MEAS);
  end

  // status contacts from flops fed by the next state, so they track it exactly
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      idle_contact_o <= 1'b1;
      meas_contact_o <= 1'b0;
      done_contact_o <= 1'b0;
    end
    else
    begin
      idle_contact_o <= (shot_state_d == alarm_cal_pkg::SHOT_IDLE);
      meas_contact_o <= (shot_state_d == alarm_cal_pkg::SHOT_MEAS);
      done_contact_o <= (shot_state_d == alarm_cal_pkg::SHOT_DONE);
    end
  end

  // reading tracks in continuous mode, held after a one-shot
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      held_reading_o <= 16'h0000;
    else if (continuous)
      held_reading_o <= conc_i;
    else if (shot_state_q == alarm_cal_pkg::SHOT_MEAS && meas_done_i)
      held_reading_o <= conc_i;
  end
endmodule

//--- rtl/alarm_cal_cfg.svh
`ifndef ALARM_CAL_CFG_SVH
`define ALARM_CAL_CFG_SVH
// Behaviour
// - each threshold alarm trips above (high) or below (low) its threshold
// - each threshold alarm relay selectable failsafe or non-failsafe
// - non-latching alarm follows the condition, drops when it ends
// - defeated alarm never actuates its relay
// - system alarm asserts when DC supply parameters are out of range
// - system alarm always failsafe and latching, cannot be disabled
// - latched system alarm clears only by power-down and restart
// - remote span enters span calibration only in continuous cycle mode
// - span calibration exits on completion, whether or not remote span is released
// - calibration contact closed for whole calibration, open otherwise
// - with contact open the device analyzes and polls span input
// - span request during calibration is discarded, never queued
// - span still asserted at completion starts another calibration
// - on completion contact opens and sample analysis resumes
// - idle, measuring, done contacts, each closed only in its state
// - done contact closed five seconds, then idle contact closes
// - held reading stays unchanged until new measurement requested
// - asserted start input triggers a new one-shot measurement (code: rising edge only, ignored while measuring or in continuous mode)

// register byte offsets
`define REG_CTRL_OFS      5'h00
`define REG_THRESH1_OFS   5'h04
`define REG_THRESH2_OFS   5'h08
`define REG_STATUS_OFS    5'h0C
`define REG_CMD_OFS       5'h10
`define REG_READING_OFS   5'h14

// control field positions, alarm n at base + 4*n
`define CTRL_EN_BIT       0
`define CTRL_HIGH_BIT     1
`define CTRL_FAILSAFE_BIT 2
`define CTRL_LATCH_BIT    3
`define CTRL_ALM_STRIDE   4
`define CTRL_CONT_BIT     8
`define CTRL_RESET        32'h0000_0100
`define THRESH_RESET      16'h0000

// command bits: write one to acknowledge a latched alarm
`define CMD_ACK1_BIT      0
`define CMD_ACK2_BIT      1

// status field positions
`define STAT_ALM1_BIT     0
`define STAT_ALM2_BIT     1
`define STAT_SYS_BIT      2
`define STAT_CAL_BIT      3
`define STAT_SHOT_LSB     4
`define STAT_SPAN_BIT     6
`define STAT_START_BIT    7

// timing
`define REF_CLK_HZ        125000000
`define DONE_HOLD_S       5
`endif

//--- rtl/alarm_cal_pkg.sv
package alarm_cal_pkg;
  typedef enum logic [0:0] {
    CAL_ANALYZE = 1'b0,
    CAL_SPAN    = 1'b1
  } cal_state_t;

  // gray order idle -> measure -> done
  typedef enum logic [1:0] {
    SHOT_IDLE = 2'b00,
    SHOT_MEAS = 2'b01,
    SHOT_DONE = 2'b11
  } shot_state_t;

  typedef logic [15:0] conc_t;
endpackage

//--- rtl/pin_sync.sv
// two-stage synchroniser for pin inputs
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

//--- rtl/threshold_alarm.sv
// one threshold alarm channel with its relay drive
module threshold_alarm (
  input  wire logic                 ref_clk_i,
  input  wire logic                 srst_i,
  input  wire alarm_cal_pkg::conc_t conc_i,
  input  wire alarm_cal_pkg::conc_t thresh_i,
  input  wire logic                 enable_i,
  input  wire logic                 high_i,
  input  wire logic                 failsafe_i,
  input  wire logic                 latch_i,
  input  wire logic                 ack_i,
  output logic                      active_o,
  output logic                      coil_o
);
  logic cond;

  // compare direction per setting
  assign cond = high_i ? (conc_i > thresh_i) : (conc_i < thresh_i);

  // alarm state: follow or hold, forced off when defeated
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      active_o <= 1'b0;
    else if (!enable_i)
      active_o <= 1'b0;
    else if (!latch_i)
      active_o <= cond;
    else
      active_o <= cond | (active_o & ~ack_i);
  end

  // relay drive: failsafe energizes when healthy
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      coil_o <= 1'b0;
    else
      coil_o <= failsafe_i ? ~active_o : active_o;
  end
endmodule

//--- verification/alarm_cal_monitor.sv
// port-level checks on contacts, pulses and coils
module alarm_cal_monitor #(
  parameter int unsigned DONE_HOLD_CYCLES = 20
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic span_cal_done_i,
  input wire logic meas_done_i,
  input wire logic span_cal_start_o,
  input wire logic meas_start_o,
  input wire logic supply_fault_i,
  input wire logic sys_alarm_coil_o,
  input wire logic cal_contact_o,
  input wire logic idle_contact_o,
  input wire logic meas_contact_o,
  input wire logic done_contact_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  logic [31:0] hold_q;

  // cycles spent with the done contact closed
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i || !done_contact_o)
      hold_q <= 32'h0;
    else
      hold_q <= hold_q + 32'h1;
  end

  AST_CAL_CLOSE_START: assert property (
    $rose(cal_contact_o) |-> span_cal_start_o) else $error("span start missing");
  AST_START_ON_CLOSE: assert property (
    span_cal_start_o |-> $rose(cal_contact_o)) else $error("stray span start");
  AST_CAL_HOLDS: assert property (
    cal_contact_o && !span_cal_done_i |=> cal_contact_o && !span_cal_start_o)
    else $error("calibration contact dropped or restarted");
  AST_CAL_OPENS: assert property (
    cal_contact_o && span_cal_done_i |=> !cal_contact_o) else $error("contact stays shut");
  AST_SHOT_ONE: assert property (
    $onehot({idle_contact_o, meas_contact_o, done_contact_o})) else $error("shot contacts");
  AST_MEAS_BEGIN: assert property (
    meas_start_o |-> $rose(meas_contact_o)) else $error("stray measure start");
  AST_MEAS_STAYS: assert property (
    meas_contact_o && !meas_done_i |=> meas_contact_o && !meas_start_o)
    else $error("measurement restarted");
  AST_MEAS_TO_DONE: assert property (
    meas_contact_o && meas_done_i |=> done_contact_o) else $error("done contact missing");
  AST_DONE_MAX: assert property (
    done_contact_o |-> hold_q < DONE_HOLD_CYCLES) else $error("done contact too long");
  AST_DONE_FULL: assert property (
    $fell(done_contact_o) && idle_contact_o |-> hold_q == DONE_HOLD_CYCLES)
    else $error("done contact too short");
  AST_SYS_TRIP: assert property (
    supply_fault_i [*6] |-> !sys_alarm_coil_o) else $error("system alarm not tripped");
  AST_SYS_LATCH: assert property (
    $fell(sys_alarm_coil_o) |=> !sys_alarm_coil_o [*8]) else $error("system alarm cleared");
endmodule

bind alarm_and_remote_cal_control alarm_cal_monitor #(
  .DONE_HOLD_CYCLES(DONE_HOLD_CYCLES)
) mon (.*);

//--- verification/proc_ctrl_model.sv
// external process controller driving the remote pins
module proc_ctrl_model (
  input  wire logic ref_clk_i,
  input  wire logic go_span_i,
  input  wire logic keep_span_i,
  input  wire logic force_span_i,
  input  wire logic go_meas_i,
  input  wire logic cal_contact_i,
  output logic      remote_span_o,
  output logic      start_meas_o,
  output logic      span_valve_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pend_q = 1'h0;
  logic [3:0] meas_q = 4'h0;

  // span request raised while open, held until the contact closes, or past that while keep_span_i is set
  always @(posedge ref_clk_i)
  begin
    if (go_span_i && !cal_contact_i)
      pend_q <= 1'h1;
    else if (cal_contact_i && !keep_span_i)
      pend_q <= 1'h0;
  end

  // start input held high for four cycles
  always @(posedge ref_clk_i)
  begin
    meas_q <= go_meas_i ? 4'hF : {1'h0, meas_q[3:1]};
  end

  // forcing breaks the handshake on purpose
  assign remote_span_o = pend_q | force_span_i;
  assign start_meas_o  = meas_q[0];
  assign span_valve_o  = pend_q | cal_contact_i;
endmodule

//--- verification/alarm_and_remote_cal_control_tb.sv
`include "alarm_cal_cfg.svh"
module alarm_and_remote_cal_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HOLD = 20;
  typedef struct packed {
    logic [7:0]  cfg;
    logic [15:0] conc;
    logic [1:0]  coil;
  } row_t;
  // alarm settings, level, expected coils {2, 1}
  row_t        rows [7] = '{'{8'h13, 16'h1001, 2'h1}, '{8'h13, 16'h0FFF, 2'h2},
    '{8'h13, 16'h1000, 2'h0}, '{8'h57, 16'h1001, 2'h2}, '{8'h06, 16'hFFFF, 2'h1},
    '{8'h75, 16'h0000, 2'h2}, '{8'h31, 16'h2000, 2'h2}};
  logic        ref_clk_i = 1'h0;
  logic        srst_i = 1'h1;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'h0;
  logic        avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [15:0] conc_i = 16'h0;
  logic [15:0] held_reading_o;
  logic        span_cal_done_i = 1'h0;
  logic        meas_done_i = 1'h0;
  logic        supply_fault_i = 1'h0;
  logic        go_span = 1'h0;
  logic        keep_span = 1'h0;
  logic        force_span = 1'h0;
  logic        go_meas = 1'h0;
  logic        span_cal_start_o, meas_start_o, remote_span_i, start_meas_i;
  logic        alarm1_coil_o, alarm2_coil_o, sys_alarm_coil_o, cal_contact_o;
  logic        idle_contact_o, meas_contact_o, done_contact_o;
  logic [31:0] rd;
  int          err_total = 0;
  int          cmp_count = 0;
  int          starts = 0;
  int          cyc = 0;
  int          n;

  alarm_and_remote_cal_control #(
    .DONE_HOLD_CYCLES(HOLD)
  ) DUT (.*);

  proc_ctrl_model ctrl (
    .ref_clk_i    (ref_clk_i),
    .go_span_i    (go_span),
    .keep_span_i  (keep_span),
    .force_span_i (force_span),
    .go_meas_i    (go_meas),
    .cal_contact_i(cal_contact_o),
    .remote_span_o(remote_span_i),
    .start_meas_o (start_meas_i),
    .span_valve_o ()
  );

  always #4 ref_clk_i = ~ref_clk_i;

  // hang guard and start pulse count
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (meas_start_o === 1'h1)
      starts <= starts + 1;
    if (cyc == 3000)
    begin
      err_total++;
      end_sim();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    do
      @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'h0);
    rd = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i  <= 1'h0;
    @(posedge ref_clk_i);
  endtask

  // one-cycle done pulse from the sequencer
  task automatic pulse(input logic m);
    meas_done_i     <= m;
    span_cal_done_i <= !m;
    tick(1);
    meas_done_i     <= 1'h0;
    span_cal_done_i <= 1'h0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    tick(4);
    srst_i <= 1'h0;
    tick(3);
    chk({idle_contact_o, meas_contact_o, done_contact_o}, 3'h4);
    chk(sys_alarm_coil_o, 1'h1);
    bus(1'h0, `REG_CTRL_OFS, 32'h0);
    chk(rd, `CTRL_RESET);
    bus(1'h0, 5'h18, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, `REG_THRESH1_OFS, 32'h1000);
    bus(1'h1, `REG_THRESH2_OFS, 32'h1000);
    foreach (rows[i])
    begin
      conc_i <= rows[i].conc;
      bus(1'h1, `REG_CTRL_OFS, {24'h1, rows[i].cfg});
      tick(4);
      chk({alarm2_coil_o, alarm1_coil_o}, rows[i].coil);
    end
    // latched alarm holds past its condition until acknowledged
    conc_i <= 16'h1001;
    bus(1'h1, `REG_CTRL_OFS, 32'h0000_010B);
    conc_i <= 16'h0800;
    tick(4);
    chk(alarm1_coil_o, 1'h1);
    bus(1'h0, `REG_STATUS_OFS, 32'h0);
    chk(rd, 32'h0000_0001);
    bus(1'h1, `REG_CMD_OFS, 32'h0000_0001);
    tick(2);
    chk(alarm1_coil_o, 1'h0);
    // span, then a forced request in mid-calibration
    go_span <= 1'h1;
    tick(1);
    go_span <= 1'h0;
    while (cal_contact_o !== 1'h1) @(posedge ref_clk_i);
    force_span <= 1'h1;
    tick(8);
    force_span <= 1'h0;
    tick(4);
    chk(cal_contact_o, 1'h1);
    pulse(1'h0);
    tick(1);
    chk(cal_contact_o, 1'h0);
    tick(8);
    chk(cal_contact_o, 1'h0);
    // request kept past completion repeats the calibration
    keep_span <= 1'h1;
    go_span   <= 1'h1;
    tick(1);
    go_span <= 1'h0;
    while (cal_contact_o !== 1'h1) @(posedge ref_clk_i);
    pulse(1'h0);
    tick(3);
    chk(cal_contact_o, 1'h1);
    keep_span <= 1'h0;
    tick(6);
    pulse(1'h0);
    tick(8);
    chk(cal_contact_o, 1'h0);
    // one-shot mode refuses span and runs a measurement
    bus(1'h1, `REG_CTRL_OFS, 32'h0);
    force_span <= 1'h1;
    tick(8);
    force_span <= 1'h0;
    chk(cal_contact_o, 1'h0);
    go_meas <= 1'h1;
    tick(1);
    go_meas <= 1'h0;
    while (meas_contact_o !== 1'h1) @(posedge ref_clk_i);
    tick(6);
    go_meas <= 1'h1;
    tick(1);
    go_meas <= 1'h0;
    tick(8);
    chk(starts, 1);
    conc_i <= 16'h0456;
    pulse(1'h1);
    conc_i <= 16'h0789;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (done_contact_o === 1'h1);
    chk(n, HOLD + 1);
    chk(idle_contact_o, 1'h1);
    chk(held_reading_o, 16'h0456);
    bus(1'h0, `REG_READING_OFS, 32'h0);
    chk(rd, 32'h0456);
    // supply fault latches until the next reset
    supply_fault_i <= 1'h1;
    tick(8);
    supply_fault_i <= 1'h0;
    tick(8);
    chk(sys_alarm_coil_o, 1'h0);
    srst_i <= 1'h1;
    tick(4);
    srst_i <= 1'h0;
    tick(3);
    chk(sys_alarm_coil_o, 1'h1);
    end_sim();
  end
endmodule
